// File: logic/mfbi_pkg.sv
// Purpose: Shared constants and types of the motor fault and brake interlock
// Assumes: 100 MHz aclk, AXI4-Lite with 32-bit data
// Notes:   Byte offsets on a 6-bit address, one word per register
package mfbi_pkg;
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned N_DOUT = 5;
   localparam logic [5:0] OFF_CTRL     = 6'h00;
   localparam logic [5:0] OFF_MODE     = 6'h04;
   localparam logic [5:0] OFF_FACTORY  = 6'h08;
   localparam logic [5:0] OFF_BRK_SEL  = 6'h0c;
   localparam logic [5:0] OFF_DOUT     = 6'h10;
   localparam logic [5:0] OFF_STATUS   = 6'h14;
   localparam logic [5:0] OFF_IRQ_STAT = 6'h18;
   localparam logic [5:0] OFF_IRQ_MASK = 6'h1c;
   localparam logic [5:0] OFF_LIMIT    = 6'h20;
   // Field positions
   localparam int unsigned CTRL_EN_BIT  = 0;
   localparam int unsigned CTRL_DIS_BIT = 1;
   localparam int unsigned MODE_RET_LSB = 4;
   localparam int unsigned ST_PWR_BIT   = 2;
   localparam int unsigned ST_FAIL_LSB  = 4;
   localparam int unsigned ST_SHORT_BIT = 7;
   localparam int unsigned ST_ERR_LSB   = 8;
   // Reset values and codes
   localparam logic [3:0]  MODE_RST        = 4'h0;
   localparam logic [3:0]  RETAIN_RST      = 4'h1;
   localparam logic [7:0]  FACTORY_CMD     = 8'h0a;
   localparam logic [15:0] OC_ERR_CODE     = 16'h0001;
   localparam logic [1:0]  FAIL_LIMIT      = 2'h3;
   localparam logic [2:0]  SEL_NONE        = 3'h0;
   localparam logic [2:0]  SEL_FOURTH      = 3'h4;
   localparam logic [3:0]  MODE_BRK_LIMIT  = 4'h6;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;
   localparam int unsigned N_IRQ           = 5;
   localparam int unsigned IRQ_FAULT       = 0;
   localparam int unsigned IRQ_RETRY_FAIL  = 1;
   localparam int unsigned IRQ_LOCK        = 2;
   localparam int unsigned IRQ_REFUSED     = 3;
   localparam int unsigned IRQ_UNLOCK      = 4;
   // Timing
   localparam longint unsigned CLK_HZ      = 100_000_000;
   localparam longint unsigned LOCK_S      = 60;
   localparam longint unsigned LOCK_CYCLES = LOCK_S * CLK_HZ;
   localparam int unsigned     LOCK_W      = 40;

   typedef enum logic [1:0] {
      PS_OFF   = 2'b00,
      PS_ON    = 2'b01,
      PS_FAULT = 2'b11,
      PS_LOCK  = 2'b10
   } mfbi_ps_e;

   typedef struct packed {
      logic phase_gnd;
      logic phase_phase;
   } mfbi_short_s;

   // Factory brake assignment per operating mode
   function automatic logic [2:0] mfbi_default_sel(input logic [3:0] mode);
      return (mode < MODE_BRK_LIMIT) ? SEL_FOURTH : SEL_NONE;
   endfunction : mfbi_default_sel
endpackage : mfbi_pkg

// File: logic/mfbi_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Input asynchronous to aclk
// Notes:   Output moves only when the second and third stages agree
`timescale 1ns/1ps
module mfbi_sync #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         ce,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] q_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         q_ff  <= '0;
      end else if (ce) begin
         s1_ff <= d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff) begin
            q_ff <= s3_ff;
         end
      end
   end

   assign q = q_ff;
endmodule : mfbi_sync

// File: logic/mfbi_route.sv
// Purpose: Routes the brake release function onto one digital output
// Assumes: sel 1..N names an output, anything else leaves all general
// Notes:   Outputs are registered
`timescale 1ns/1ps
module mfbi_route #(
   parameter int unsigned N = 5
) (
   // Clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         ce,
   // Control
   input  wire logic [2:0]   sel,
   input  wire logic         brake_release,
   input  wire logic [N-1:0] gp,
   // Pins
   output logic      [N-1:0] dout
);
   logic [N-1:0] dout_ff;

   for (genvar i = 0; i < N; i++) begin : g_out
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            dout_ff[i] <= 1'b0;
         end else if (ce) begin
            dout_ff[i] <= (sel == 3'(i + 1)) ? brake_release : gp[i];
         end
      end
   end

   assign dout = dout_ff;
endmodule : mfbi_route

// File: logic/mfbi_top.sv
// Purpose: Power stage interlock, retry lockout and brake output routing
// Assumes: Short detector flags and mode switch pins are asynchronous
// Notes:   AXI4-Lite register slave; one level interrupt
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module mfbi_top #(
   parameter logic [mfbi_pkg::LOCK_W-1:0] LOCK_CYCLES =
      mfbi_pkg::LOCK_W'(mfbi_pkg::LOCK_CYCLES)
) (
   // Clock, reset, enable
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   input  wire logic                       ce,
   // AXI4-Lite write address
   input  wire logic [mfbi_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                       awvalid,
   output logic                            awready,
   // AXI4-Lite write data
   input  wire logic [31:0]                wdata,
   input  wire logic [3:0]                 wstrb,
   input  wire logic                       wvalid,
   output logic                            wready,
   // AXI4-Lite write response
   output logic      [1:0]                 bresp,
   output logic                            bvalid,
   input  wire logic                       bready,
   // AXI4-Lite read
   input  wire logic [mfbi_pkg::ADDR_W-1:0] araddr,
   input  wire logic                       arvalid,
   output logic                            arready,
   output logic      [31:0]                rdata,
   output logic      [1:0]                 rresp,
   output logic                            rvalid,
   input  wire logic                       rready,
   // Motor side
   input  wire mfbi_pkg::mfbi_short_s      short_in,
   input  wire logic [3:0]                 mode_switch_position_input,
   output logic                            power_stage_en,
   output logic [mfbi_pkg::N_DOUT-1:0]     digital_output,
   // Interrupt
   output logic                            irq
);
   // Bus state
   logic                        awready_ff;
   logic                        wready_ff;
   logic                        aw_hold_ff;
   logic                        w_hold_ff;
   logic [mfbi_pkg::ADDR_W-1:0] waddr_ff;
   logic [31:0]                 wdata_ff;
   logic                        wlane0_ff;
   logic                        bvalid_ff;
   logic [1:0]                  bresp_ff;
   logic                        arready_ff;
   logic                        rvalid_ff;
   logic [31:0]                 rdata_ff;
   logic [1:0]                  rresp_ff;
   // Block state
   mfbi_pkg::mfbi_ps_e          ps_ff;
   mfbi_pkg::mfbi_ps_e          nxt_ps;
   logic [1:0]                  fail_ff;
   logic [1:0]                  nxt_fail;
   logic [mfbi_pkg::LOCK_W-1:0] lock_cnt_ff;
   logic [15:0]                 err_ff;
   logic                        power_ff;
   logic [3:0]                  mode_ff;
   logic [3:0]                  retain_ff;
   logic [2:0]                  sel_ff;
   logic [mfbi_pkg::N_DOUT-1:0] gp_ff;
   logic [3:0]                  ms_last_ff;
   logic [mfbi_pkg::N_IRQ-1:0]  irq_stat_ff;
   logic [mfbi_pkg::N_IRQ-1:0]  irq_mask_ff;
   logic [mfbi_pkg::N_IRQ-1:0]  ev;
   logic [mfbi_pkg::N_IRQ-1:0]  nxt_irq_stat;
   logic                        irq_ff;
   // Decoded strobes
   logic                        wr_do;
   logic                        wr_low;
   logic                        wr_ok;
   logic                        rd_take;
   logic                        en_req;
   logic                        dis_req;
   logic                        mode_wr;
   logic                        ms_change;
   logic [3:0]                  new_mode;
   logic [3:0]                  new_retain;
   logic                        factory_wr;
   logic [1:0]                  short_sync;
   logic                        short_now;
   logic [3:0]                  ms_sync;
   logic [31:0]                 rd_word;

   // Pin synchronisers
   mfbi_sync #(.W(2)) u_short_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .d       (short_in),
      .q       (short_sync)
   );

   mfbi_sync #(.W(4)) u_mode_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .d       (mode_switch_position_input),
      .q       (ms_sync)
   );

   // Only phase-phase and phase-ground detectors exist here; nothing watches
   // the bus, resistor or brake wires, so shorts there never fault.
   assign short_now = |short_sync;

   assign wr_do   = aw_hold_ff && w_hold_ff && !bvalid_ff;
   assign wr_ok   = waddr_ff < mfbi_pkg::OFF_LIMIT && waddr_ff[1:0] == 2'b00;
   assign wr_low  = wr_do && wr_ok && wlane0_ff;
   assign rd_take = arvalid && arready_ff;

   assign en_req  = wr_low && waddr_ff == mfbi_pkg::OFF_CTRL &&
                    wdata_ff[mfbi_pkg::CTRL_EN_BIT];
   assign dis_req = wr_low && waddr_ff == mfbi_pkg::OFF_CTRL &&
                    wdata_ff[mfbi_pkg::CTRL_DIS_BIT];
   assign mode_wr    = wr_low && waddr_ff == mfbi_pkg::OFF_MODE;
   assign factory_wr = wr_low && waddr_ff == mfbi_pkg::OFF_FACTORY &&
                       wdata_ff[7:0] == mfbi_pkg::FACTORY_CMD;
   assign ms_change  = ms_sync != ms_last_ff;
   assign new_mode   = mode_wr ? wdata_ff[3:0] : ms_sync;
   assign new_retain = mode_wr ? wdata_ff[mfbi_pkg::MODE_RET_LSB +: 4] : retain_ff;

   // Write address and data are taken independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b1;
         aw_hold_ff <= 1'b0;
         waddr_ff   <= '0;
      end else if (ce) begin
         if (awvalid && awready_ff) begin
            awready_ff <= 1'b0;
            aw_hold_ff <= 1'b1;
            waddr_ff   <= awaddr;
         end else if (wr_do) begin
            awready_ff <= 1'b1;
            aw_hold_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_ff <= 1'b1;
         w_hold_ff <= 1'b0;
         wdata_ff  <= '0;
         wlane0_ff <= 1'b0;
      end else if (ce) begin
         if (wvalid && wready_ff) begin
            wready_ff <= 1'b0;
            w_hold_ff <= 1'b1;
            wdata_ff  <= wdata;
            wlane0_ff <= wstrb[0];
         end else if (wr_do) begin
            wready_ff <= 1'b1;
            w_hold_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= mfbi_pkg::RESP_OKAY;
      end else if (ce) begin
         if (wr_do) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_ok ? mfbi_pkg::RESP_OKAY : mfbi_pkg::RESP_SLVERR;
         end else if (bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // Read data mux
   always_comb begin
      rd_word = '0;
      unique case (araddr)
         mfbi_pkg::OFF_MODE:     rd_word = {24'h0, retain_ff, mode_ff};
         mfbi_pkg::OFF_BRK_SEL:  rd_word = {29'h0, sel_ff};
         mfbi_pkg::OFF_DOUT:     rd_word = {27'h0, gp_ff};
         mfbi_pkg::OFF_STATUS:   rd_word = {8'h0, err_ff, short_now, 1'b0, fail_ff,
                                            1'b0, power_ff, ps_ff};
         mfbi_pkg::OFF_IRQ_STAT: rd_word = {27'h0, irq_stat_ff};
         mfbi_pkg::OFF_IRQ_MASK: rd_word = {27'h0, irq_mask_ff};
         default:                rd_word = '0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= '0;
         rresp_ff   <= mfbi_pkg::RESP_OKAY;
      end else if (ce) begin
         if (rd_take) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= rd_word;
            rresp_ff   <= (araddr < mfbi_pkg::OFF_LIMIT && araddr[1:0] == 2'b00) ?
                          mfbi_pkg::RESP_OKAY : mfbi_pkg::RESP_SLVERR;
         end else if (rvalid_ff && rready) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
         end
      end
   end

   // Power stage state machine
   always_comb begin
      nxt_ps   = ps_ff;
      nxt_fail = fail_ff;
      ev       = '0;
      unique case (ps_ff)
         mfbi_pkg::PS_OFF: begin
            if (en_req) begin
               nxt_ps = mfbi_pkg::PS_ON;
            end
         end
         mfbi_pkg::PS_ON: begin
            if (short_now) begin
               nxt_ps = mfbi_pkg::PS_FAULT;
               ev[mfbi_pkg::IRQ_FAULT] = 1'b1;
            end else if (dis_req) begin
               nxt_ps = mfbi_pkg::PS_OFF;
            end
         end
         mfbi_pkg::PS_FAULT: begin
            if (en_req && short_now) begin
               nxt_fail = fail_ff + 2'd1;
               ev[mfbi_pkg::IRQ_RETRY_FAIL] = 1'b1;
               if (nxt_fail == mfbi_pkg::FAIL_LIMIT) begin
                  nxt_ps = mfbi_pkg::PS_LOCK;
                  ev[mfbi_pkg::IRQ_LOCK] = 1'b1;
               end
            end else if (en_req) begin
               nxt_ps   = mfbi_pkg::PS_ON;
               nxt_fail = '0;
            end
         end
         mfbi_pkg::PS_LOCK: begin
            ev[mfbi_pkg::IRQ_REFUSED] = en_req;
            if (lock_cnt_ff == '0) begin
               nxt_ps   = mfbi_pkg::PS_FAULT;
               nxt_fail = '0;
               ev[mfbi_pkg::IRQ_UNLOCK] = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ps_ff    <= mfbi_pkg::PS_OFF;
         fail_ff  <= '0;
         power_ff <= 1'b0;
      end else if (ce) begin
         ps_ff    <= nxt_ps;
         fail_ff  <= nxt_fail;
         power_ff <= nxt_ps == mfbi_pkg::PS_ON;
      end
   end

   // Lockout timer holds off resets for the full minute
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lock_cnt_ff <= '0;
      end else if (ce) begin
         if (ps_ff != mfbi_pkg::PS_LOCK) begin
            lock_cnt_ff <= LOCK_CYCLES - mfbi_pkg::LOCK_W'(1);
         end else if (lock_cnt_ff != '0) begin
            lock_cnt_ff <= lock_cnt_ff - mfbi_pkg::LOCK_W'(1);
         end
      end
   end

   // Error code stays until a reset attempt succeeds
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         err_ff <= '0;
      end else if (ce) begin
         if (ev[mfbi_pkg::IRQ_FAULT]) begin
            err_ff <= mfbi_pkg::OC_ERR_CODE;
         end else if (ps_ff == mfbi_pkg::PS_FAULT && nxt_ps == mfbi_pkg::PS_ON) begin
            err_ff <= '0;
         end
      end
   end

   // Operating mode and output assignment
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_ff    <= mfbi_pkg::MODE_RST;
         retain_ff  <= mfbi_pkg::RETAIN_RST;
         sel_ff     <= mfbi_pkg::mfbi_default_sel(mfbi_pkg::MODE_RST);
         ms_last_ff <= '0;
      end else if (ce) begin
         ms_last_ff <= ms_sync;
         if (mode_wr || ms_change) begin
            mode_ff   <= new_mode;
            retain_ff <= new_retain;
            if (new_retain != 4'h0) begin
               sel_ff <= mfbi_pkg::mfbi_default_sel(new_mode);
            end
         end else if (factory_wr) begin
            sel_ff <= mfbi_pkg::mfbi_default_sel(mode_ff);
         end else if (wr_low && waddr_ff == mfbi_pkg::OFF_BRK_SEL) begin
            sel_ff <= wdata_ff[2:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gp_ff       <= '0;
         irq_mask_ff <= '0;
      end else if (ce) begin
         if (wr_low && waddr_ff == mfbi_pkg::OFF_DOUT) begin
            gp_ff <= wdata_ff[mfbi_pkg::N_DOUT-1:0];
         end
         if (wr_low && waddr_ff == mfbi_pkg::OFF_IRQ_MASK) begin
            irq_mask_ff <= wdata_ff[mfbi_pkg::N_IRQ-1:0];
         end
      end
   end

   // Interrupt status clears on read; a same-cycle event survives
   assign nxt_irq_stat = ((rd_take && araddr == mfbi_pkg::OFF_IRQ_STAT) ?
                          '0 : irq_stat_ff) | ev;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_ff <= '0;
         irq_ff      <= 1'b0;
      end else if (ce) begin
         irq_stat_ff <= nxt_irq_stat;
         irq_ff      <= |(nxt_irq_stat & irq_mask_ff);
      end
   end

   // Brake release is driven straight from the power stage state; an
   // emergency stop path must still drop the brake outside this block.
   mfbi_route #(.N(mfbi_pkg::N_DOUT)) u_route (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .ce            (ce),
      .sel           (sel_ff),
      .brake_release (power_ff),
      .gp            (gp_ff),
      .dout          (digital_output)
   );

   assign awready        = awready_ff;
   assign wready         = wready_ff;
   assign bvalid         = bvalid_ff;
   assign bresp          = bresp_ff;
   assign arready        = arready_ff;
   assign rvalid         = rvalid_ff;
   assign rdata          = rdata_ff;
   assign rresp          = rresp_ff;
   assign power_stage_en = power_ff;
   assign irq            = irq_ff;
endmodule : mfbi_top

// File: tb/mfbi_assertions.sv
// Purpose: Port-level checks of the interlock block
// Assumes: One clock domain, ce held high by the bench
// Notes:   Bound into mfbi_top
`timescale 1ns/1ps
module mfbi_chk (
   // Clock, reset, enable
   input wire logic                  aclk,
   input wire logic                  aresetn,
   input wire logic                  ce,
   // Bus
   input wire logic                  awvalid,
   input wire logic                  awready,
   input wire logic                  wvalid,
   input wire logic                  wready,
   input wire logic [1:0]            bresp,
   input wire logic                  bvalid,
   input wire logic                  bready,
   input wire logic                  arvalid,
   input wire logic                  arready,
   input wire logic [31:0]           rdata,
   input wire logic [1:0]            rresp,
   input wire logic                  rvalid,
   input wire logic                  rready,
   // Motor side
   input wire mfbi_pkg::mfbi_short_s short_in,
   input wire logic                  power_stage_en,
   input wire logic [4:0]            digital_output,
   input wire logic                  irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Synchroniser plus state update leave about five edges of slack
   property p_short_off;
      ce && power_stage_en && $rose(short_in != 2'b00) |-> ##[1:10] !power_stage_en;
   endproperty
   a_short_off: assert property (p_short_off) else $error("stage on after short");
   property p_rst_out;
      $rose(aresetn) |-> !power_stage_en && digital_output == 5'h00 && !irq && !bvalid;
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
   property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response not held");
   property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read response not held");
   property p_b_done; ce && bvalid && bready |=> !bvalid; endproperty
   a_b_done: assert property (p_b_done) else $error("write response repeated");
   property p_r_lat; ce && arvalid && arready |=> rvalid; endproperty
   a_r_lat: assert property (p_r_lat) else $error("read answer late");
   property p_w_lat;
      ce && awvalid && awready && wvalid && wready && !bvalid |=> ##1 bvalid;
   endproperty
   a_w_lat: assert property (p_w_lat) else $error("write answer late");
   property p_ar_busy; rvalid |-> !arready; endproperty
   a_ar_busy: assert property (p_ar_busy) else $error("read taken while busy");
   c_fault: cover property ($fell(power_stage_en));
   c_irq: cover property ($rose(irq));
   c_slverr: cover property (bvalid && bresp == mfbi_pkg::RESP_SLVERR);
endmodule : mfbi_chk
bind mfbi_top mfbi_chk mfbi_chk_i (.aclk, .aresetn, .ce, .awvalid, .awready, .wvalid, .wready,
   .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
   .short_in, .power_stage_en, .digital_output, .irq);

// File: tb/mfbi_motor.sv
// Purpose: Motor phase and holding brake stand-in
// Assumes: Bench drives each fault kind
// Notes:   Shorts to bus, resistor or brake wires have no path to the flags
`timescale 1ns/1ps
module mfbi_motor (
   // Clock
   input wire logic              aclk,
   // Fault and stop commands
   input wire logic              pp_cmd,
   input wire logic              pg_cmd,
   input wire logic              estop,
   // Drive side
   input wire logic              brake_rel,
   output mfbi_pkg::mfbi_short_s short_in,
   output logic                  brake_held
);
   // Only phase and ground faults reach the detector
   always @(posedge aclk) short_in <= {pg_cmd, pp_cmd};
   // A stop holds the shaft whatever the drive asks
   assign brake_held = estop || !brake_rel;
endmodule : mfbi_motor

// File: tb/mfbi_top_tb.sv
// Purpose: Self-checking bench of the interlock block
// Assumes: Short lock period, ce held high
// Notes:   Model state kept in plain integers
`timescale 1ns/1ps
module mfbi_top_tb;
   localparam int LC = 20;
   logic                  aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
   logic                  awready, wready, bvalid, arready, rvalid, pse, irq, pp, pg, bh, es;
   logic [5:0]            awaddr, araddr;
   logic [31:0]           wdata, rdata;
   logic [3:0]            wstrb, msp;
   logic [1:0]            bresp, rresp;
   logic [4:0]            dout;
   mfbi_pkg::mfbi_short_s sh;
   int n_mismatch, n_compared, m_sel, m_mode, m_ret, m_dv, m_st, m_fail, m_code, m_ist, m_msk;
   int m_sh;
   mfbi_top #(.LOCK_CYCLES(LC)) mfbi_top_i (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready, .short_in(sh), .mode_switch_position_input(msp),
      .power_stage_en(pse), .digital_output(dout), .irq);
   mfbi_motor mfbi_motor_i (.aclk, .pp_cmd(pp), .pg_cmd(pg), .estop(es),
      .brake_rel(dout[3]), .short_in(sh), .brake_held(bh));
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic end_sim;
      if (n_mismatch == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp
   task automatic tmo(input int n);
      if (n > 100) begin
         n_mismatch++;
         end_sim();
      end
   endtask : tmo
   task automatic tk(input int n);
      repeat (n) @(posedge aclk);
   endtask : tk
   function automatic logic [1:0] ersp(input logic [5:0] a);
      return (a >= 6'h20 || a[1:0] != 2'h0) ? mfbi_pkg::RESP_SLVERR : mfbi_pkg::RESP_OKAY;
   endfunction : ersp
   function automatic int dflt(input int m);
      return (m < mfbi_pkg::MODE_BRK_LIMIT) ? 4 : 0;
   endfunction : dflt
   function automatic logic [31:0] exp_rd(input logic [5:0] a);
      case (a)
         mfbi_pkg::OFF_MODE:     return m_ret * 16 + m_mode;
         mfbi_pkg::OFF_BRK_SEL:  return m_sel;
         mfbi_pkg::OFF_DOUT:     return m_dv;
         mfbi_pkg::OFF_STATUS:   return m_code * 256 + m_sh * 128 + m_fail * 16 + (m_st == 1) * 4 + m_st;
         mfbi_pkg::OFF_IRQ_STAT: return m_ist;
         mfbi_pkg::OFF_IRQ_MASK: return m_msk;
         default:                return 0;
      endcase
   endfunction : exp_rd
   task automatic wr(input logic [5:0] a, input int d);
      logic ta, td;
      int   n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      {awvalid, wvalid, bready} <= 3'b111;
      {ta, td, n} = '0;
      do begin
         @(posedge aclk);
         n++;
         tmo(n);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         ta |= awready;
         td |= wready;
      end while (!(ta && td));
      do begin
         @(posedge aclk);
         n++;
         tmo(n);
      end while (!bvalid);
      bready <= 1'b0;
      cmp("bresp", ersp(a), bresp);
   endtask : wr
   task automatic rdc(input logic [5:0] a);
      int n;
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'b11;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         tmo(n);
      end while (!arready);
      arvalid <= 1'b0;
      do begin
         @(posedge aclk);
         n++;
         tmo(n);
      end while (!rvalid);
      rready <= 1'b0;
      cmp($sformatf("rdata %h", a), exp_rd(a), rdata);
      cmp("rresp", ersp(a), rresp);
      if (a == mfbi_pkg::OFF_IRQ_STAT) m_ist = 0;
   endtask : rdc
   // A fault only latches while the stage runs; an off stage cannot sense it
   task automatic flt(input logic a, input logic b);
      pp <= a;
      pg <= b;
      m_sh = a | b;
      tk(10);
      if (m_sh != 0 && m_st == 1) begin
         m_st = 3;
         m_code = 1;
         m_ist |= 1;
      end
      cmp("power", m_st == 1, pse);
   endtask : flt
   task automatic en(input int x);
      wr(mfbi_pkg::OFF_CTRL, x ? 1 : 2);
      m_st = x;
      if (x) {m_code, m_fail} = '0;
      tk(4);
   endtask : en
   task automatic cdo;
      logic [4:0] v;
      v = 5'(m_dv);
      if (m_sel > 0 && m_sel < 6) v[m_sel-1] = (m_st == 1);
      cmp("dout", v, dout);
      cmp("brake", es || !v[3], bh);
   endtask : cdo
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, pp, pg, es} = '0;
      {awaddr, araddr, wdata, wstrb, msp} = '0;
      ce = 1'b1;
      {n_mismatch, n_compared, m_mode, m_dv, m_st, m_fail, m_code, m_ist, m_msk, m_sh} = '0;
      m_sel = 4;
      m_ret = 1;
      void'($urandom(78));
      tk(12);
      aresetn <= 1'b1;
      for (int a = 0; a < 'h28; a += 4) rdc(6'(a));
      rdc(6'h02);
      wr(6'h24, 1);
      for (int s = 0; s < 8; s++) begin
         m_dv = $urandom_range(31);
         es <= ~es;
         m_sel = s;
         wr(mfbi_pkg::OFF_DOUT, m_dv);
         wr(mfbi_pkg::OFF_BRK_SEL, s);
         en(1);
         cdo();
         en(0);
         cdo();
      end
      for (int k = 0; k < 2; k++) begin
         m_msk = k * 31;
         wr(mfbi_pkg::OFF_IRQ_MASK, m_msk);
         en(1);
         flt(1'(!k), 1'(k));
         wr(mfbi_pkg::OFF_CTRL, 1);
         m_fail = 1;
         m_ist |= 2;
         rdc(mfbi_pkg::OFF_STATUS);
         cmp("irq", k, irq);
         flt(0, 0);
         en(1);
         rdc(mfbi_pkg::OFF_STATUS);
         en(0);
      end
      rdc(mfbi_pkg::OFF_IRQ_STAT);
      tk(3);
      cmp("irq", 0, irq);
      en(1);
      flt(1, 0);
      for (int i = 1; i < 5; i++) begin
         wr(mfbi_pkg::OFF_CTRL, 1);
         m_fail = i < 4 ? i : 3;
         m_st = i < 3 ? 3 : 2;
         m_ist |= i < 3 ? 2 : i == 3 ? 6 : 8;
         rdc(mfbi_pkg::OFF_STATUS);
      end
      tk(LC);
      {m_st, m_fail} = {32'sd3, 32'sd0};
      m_ist |= 16;
      rdc(mfbi_pkg::OFF_STATUS);
      rdc(mfbi_pkg::OFF_IRQ_STAT);
      flt(0, 0);
      en(1);
      rdc(mfbi_pkg::OFF_STATUS);
      en(0);
      for (int i = 0; i < 4; i++) begin
         wr(mfbi_pkg::OFF_BRK_SEL, 2);
         m_sel = 2;
         m_mode = i < 2 ? 5 + i : $urandom_range(15);
         m_ret = i < 2 ? i + 1 : 0;
         if (m_ret != 0) m_sel = dflt(m_mode);
         wr(mfbi_pkg::OFF_MODE, m_ret * 16 + m_mode);
         rdc(mfbi_pkg::OFF_BRK_SEL);
      end
      for (int i = 0; i < 3; i++) begin
         m_mode = i * 5;
         wr(mfbi_pkg::OFF_MODE, m_mode);
         wr(mfbi_pkg::OFF_FACTORY, i == 0 ? 'h0b : 'h0a);
         if (i != 0) m_sel = dflt(m_mode);
         rdc(mfbi_pkg::OFF_BRK_SEL);
      end
      m_ret = 1;
      m_sel = dflt(m_mode);
      wr(mfbi_pkg::OFF_MODE, 16 + m_mode);
      for (int i = 0; i < 2; i++) begin
         msp <= i ? 4'h9 : 4'h3;
         m_mode = i ? 9 : 3;
         if (m_ret != 0) m_sel = dflt(m_mode);
         tk(8);
         rdc(mfbi_pkg::OFF_MODE);
         rdc(mfbi_pkg::OFF_BRK_SEL);
         m_ret = 0;
         wr(mfbi_pkg::OFF_MODE, m_mode);
      end
      end_sim();
   end
endmodule : mfbi_top_tb
